//--- pkg/lfm_pkg.sv
// Shared constants and types for the flash target read port
package lfm_pkg;

  // Start and field codes on the nibble bus
  localparam logic [3:0] START_FW_READ  = 4'hD;
  localparam logic [3:0] START_FW_WRITE = 4'hE;
  localparam logic [3:0] START_LPC_MEM  = 4'h0;
  localparam logic [3:0] SIZE_ONE_BYTE  = 4'h0;
  localparam logic [3:0] SYNC_READY     = 4'h0;
  localparam logic [3:0] TAR_ONES       = 4'hF;

  // Field positions and widths
  localparam int         ADDR_BITS      = 28;
  localparam logic [2:0] ADDR_LAST      = 3'h6;
  localparam int         DIR_BIT        = 1;
  localparam int         PP_ADDR_PINS   = 11;
  localparam int         ARRAY_AW       = 19;

  // Identification map
  localparam logic [27:0] LPC_IDENT_BASE = 28'hFBC0000;
  localparam logic [27:0] PP_IDENT_BASE  = 28'h0000000;

  typedef enum logic [3:0] {
    PH_IDLE, PH_START, PH_ADDR, PH_SIZE, PH_TAR0, PH_TAR1,
    PH_SYNC, PH_DLO, PH_DHI, PH_TBACK, PH_SKIP
  } lfm_phase_type;

  // Nibble bus drive, enable low while driving
  typedef struct packed {
    logic [3:0] data;
    logic       oe_n;
  } lfm_lad_type;

  typedef struct packed {
    lfm_phase_type  phase;
    logic [3:0]     start;
    logic [2:0]     cnt;
    logic [27:0]    addr;
    logic [7:0]     rdata;
    logic           mem_write;
    logic           standby;
    lfm_lad_type    lad;
  } lfm_lpc_state_type;

  typedef struct packed {
    logic [27:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe_n;
    logic        we_q;
    logic        wr_strobe;
    logic [7:0]  wr_data;
  } lfm_pp_state_type;

  localparam lfm_lad_type LAD_RESET = '{data: 4'hF, oe_n: 1'b1};

  localparam lfm_lpc_state_type LPC_RESET = '{
    phase: PH_IDLE, start: 4'hF, cnt: 3'h0, addr: 28'h0000000,
    rdata: 8'h00, mem_write: 1'b0, standby: 1'b0, lad: LAD_RESET};

  localparam lfm_pp_state_type PP_RESET = '{
    addr: 28'h0000000, dq_out: 8'h00, dq_oe_n: 1'b1, we_q: 1'b1,
    wr_strobe: 1'b0, wr_data: 8'h00};

endpackage

//--- src/lfm_pp_port.sv
// Parallel programming port: multiplexed address, data drive, write
`timescale 1ns/1ns
module lfm_pp_port #(
  parameter int AW = lfm_pkg::ARRAY_AW
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Mode
  input  wire logic        enable,
  // Pins
  input  wire logic [10:0] addr_pins,
  input  wire logic        row_sel,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  dq_in,
  // Array side
  input  wire logic [7:0]  rd_byte,
  output lfm_pkg::lfm_pp_state_type state
);

  lfm_pkg::lfm_pp_state_type s;
  lfm_pkg::lfm_pp_state_type next_s;

  // Column pins reach only eleven bits above the row
  if (AW < 12 || AW > 2 * lfm_pkg::PP_ADDR_PINS) begin : g_aw_check
    $error("AW out of range");
  end

  always_comb begin
    next_s = s;
    next_s.wr_strobe = 1'b0;
    if (enable) begin
      if (row_sel) begin
        next_s.addr[10:0] = addr_pins;
      end else begin
        for (int i = 11; i < AW; i++) begin
          next_s.addr[i] = addr_pins[i-11];
        end
      end
      next_s.dq_oe_n = oe_n;
      next_s.dq_out = rd_byte;
      next_s.we_q = we_n;
      if (!s.we_q && we_n) begin
        next_s.wr_strobe = 1'b1;
        next_s.wr_data = dq_in;
      end
    end else begin
      next_s = lfm_pkg::PP_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= lfm_pkg::PP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign state = s;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pp_oe_gate_a: assert property (
    !enable || oe_n |=> state.dq_oe_n)
    else $error("parallel data driven without enable");
  pp_row_load_a: assert property (
    enable && row_sel |=> state.addr[10:0] == $past(addr_pins))
    else $error("row address not loaded");
  pp_write_a: assert property (
    enable && !we_n ##1 enable && we_n |=> state.wr_strobe)
    else $error("write strobe missing");
  pp_write_c: cover property (state.wr_strobe);

endmodule

//--- src/lfm_target.sv
// Flash target host port: nibble bus read cycles and parallel mode
`timescale 1ns/1ns
// Summary of operation
// - MODE high selects parallel mode, low selects the nibble bus.
// - A floating MODE reads low, so the nibble bus is used.
// - Start 1101 reads, 1110 writes, 0000 memory cycle; others ignored.
// - Start nibble is the last one seen while the frame strobe is low.
// - Frame strobe low mid-cycle aborts and restarts start detection.
// - Standby in nibble bus mode when frame strobe is high, no read is in progress and nothing is programming.
// - Memory cycle direction comes from the nibble after the start.
// - Second clock select nibble must equal the strap inputs.
// - Seven address nibbles, most significant first, form 28 bits.
// - Size nibble 0000 means one byte, the only size served.
// - Device takes the bus in clock twelve.
// - Device drives ready code 0000 in clock thirteen.
// - Low data nibble in clock fourteen, high in fifteen.
// - Device drives ones in clock sixteen, then releases.
// - Every field is valid at the clock edge of its cycle.
// - Parallel row select loads low address bits, column the upper.
// - Parallel data drives only with output enable low; WE writes.
// - Identification mode returns maker and device codes at 0 and 1 in parallel mode, FBC0000 and FBC0001 on the nibble bus.
// - Either reset low deselects and floats the nibble bus.
module lfm_target #(
  parameter int         AW       = lfm_pkg::ARRAY_AW,
  // Arbitrary identification values
  parameter logic [7:0] MFR_CODE = 8'hA5,
  parameter logic [7:0] DEV_CODE = 8'h3C
) (
  // Clock and resets
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        INIT_N,
  // Mode and status
  input  wire logic        MODE,
  input  wire logic        IDENT_MODE,
  input  wire logic        PROG_BUSY,
  output logic             STANDBY,
  output logic             LPC_MEM_WRITE,
  // Nibble bus
  input  wire logic        LFRAME_N,
  input  wire logic [3:0]  LAD_IN,
  output logic [3:0]       LAD_OUT,
  output logic             LAD_OE_N,
  input  wire logic [3:0]  ID_STRAP,
  // Parallel port
  input  wire logic [10:0] PP_ADDR,
  input  wire logic        PP_ROW_SEL,
  input  wire logic        PP_OE_N,
  input  wire logic        PP_WE_N,
  input  wire logic [7:0]  PP_DQ_IN,
  output logic [7:0]       PP_DQ_OUT,
  output logic             PP_DQ_OE_N,
  output logic             PP_WR_STROBE,
  output logic [7:0]       PP_WR_DATA,
  // Array access
  output logic [27:0]      MEM_ADDR,
  input  wire logic [7:0]  MEM_RD_DATA
);

  ////////////////////////////////////////////////////////////////////
  // Reset and mode

  logic                      rst;
  logic                      pp_mode;
  logic                      lpc_live;
  logic [7:0]                lpc_byte;
  logic [7:0]                pp_byte;
  lfm_pkg::lfm_lpc_state_type s;
  lfm_pkg::lfm_lpc_state_type next_s;
  lfm_pkg::lfm_pp_state_type  pp;

  // Column pins reach only eleven bits above the row
  if (AW < 12 || AW > 2 * lfm_pkg::PP_ADDR_PINS) begin : g_aw_check
    $error("AW out of range");
  end

  // Either reset pin acts alone
  assign rst = !RST_N || !INIT_N;
  // Only a high level selects parallel; floating reads low
  assign pp_mode = MODE == 1'b1;
  assign lpc_live = !pp_mode && LFRAME_N;

  ////////////////////////////////////////////////////////////////////
  // Identification and array data

  function automatic logic [7:0] ident_pick(
    input logic        hit,
    input logic        sel,
    input logic [7:0]  mem
  );
    logic [7:0] r;
    r = mem;
    if (hit) begin
      r = sel ? DEV_CODE : MFR_CODE;
    end
    return r;
  endfunction

  always_comb begin
    lpc_byte = ident_pick(IDENT_MODE &&
      s.addr[27:1] == lfm_pkg::LPC_IDENT_BASE[27:1],
      s.addr[0], MEM_RD_DATA);
    pp_byte = ident_pick(IDENT_MODE &&
      pp.addr[27:1] == lfm_pkg::PP_IDENT_BASE[27:1],
      pp.addr[0], MEM_RD_DATA);
  end

  ////////////////////////////////////////////////////////////////////
  // Nibble bus cycle engine

  always_comb begin
    next_s = s;
    case (s.phase)
      lfm_pkg::PH_IDLE: begin
        next_s.lad = lfm_pkg::LAD_RESET;
      end
      lfm_pkg::PH_START: begin
        // Strobe has risen; this nibble is the second field
        case (s.start)
          lfm_pkg::START_FW_READ: begin
            if (LAD_IN == ID_STRAP) begin
              next_s.phase = lfm_pkg::PH_ADDR;
              next_s.cnt = 3'h0;
            end else begin
              next_s.phase = lfm_pkg::PH_SKIP;
            end
          end
          lfm_pkg::START_FW_WRITE: begin
            next_s.phase = lfm_pkg::PH_SKIP;
          end
          lfm_pkg::START_LPC_MEM: begin
            next_s.mem_write = LAD_IN[lfm_pkg::DIR_BIT];
            next_s.phase = lfm_pkg::PH_SKIP;
          end
          default: begin
            next_s.phase = lfm_pkg::PH_IDLE;
          end
        endcase
      end
      lfm_pkg::PH_ADDR: begin
        next_s.addr = {s.addr[23:0], LAD_IN};
        next_s.cnt = s.cnt + 3'h1;
        if (s.cnt == lfm_pkg::ADDR_LAST) begin
          next_s.phase = lfm_pkg::PH_SIZE;
        end
      end
      lfm_pkg::PH_SIZE: begin
        if (LAD_IN == lfm_pkg::SIZE_ONE_BYTE) begin
          next_s.phase = lfm_pkg::PH_TAR0;
        end else begin
          next_s.phase = lfm_pkg::PH_SKIP;
        end
      end
      lfm_pkg::PH_TAR0: begin
        // Host owns clock eleven; take the bus for clock twelve
        next_s.phase = lfm_pkg::PH_TAR1;
        next_s.rdata = lpc_byte;
        next_s.lad = '{data: lfm_pkg::TAR_ONES, oe_n: 1'b0};
      end
      lfm_pkg::PH_TAR1: begin
        next_s.phase = lfm_pkg::PH_SYNC;
        next_s.lad.data = lfm_pkg::SYNC_READY;
      end
      lfm_pkg::PH_SYNC: begin
        next_s.phase = lfm_pkg::PH_DLO;
        next_s.lad.data = s.rdata[3:0];
      end
      lfm_pkg::PH_DLO: begin
        next_s.phase = lfm_pkg::PH_DHI;
        next_s.lad.data = s.rdata[7:4];
      end
      lfm_pkg::PH_DHI: begin
        next_s.phase = lfm_pkg::PH_TBACK;
        next_s.lad.data = lfm_pkg::TAR_ONES;
      end
      lfm_pkg::PH_TBACK: begin
        // Float before clock seventeen so the host can take over
        next_s.phase = lfm_pkg::PH_IDLE;
        next_s.lad = lfm_pkg::LAD_RESET;
      end
      lfm_pkg::PH_SKIP: begin
        next_s.lad = lfm_pkg::LAD_RESET;
      end
      default: begin
        next_s.phase = lfm_pkg::PH_IDLE;
        next_s.lad = lfm_pkg::LAD_RESET;
      end
    endcase
    // Strobe low starts or aborts; keep the latest nibble
    if (!LFRAME_N) begin
      next_s.phase = lfm_pkg::PH_START;
      next_s.start = LAD_IN;
      next_s.lad = lfm_pkg::LAD_RESET;
    end
    next_s.standby = LFRAME_N && !PROG_BUSY &&
      next_s.phase != lfm_pkg::PH_START &&
      (next_s.phase == lfm_pkg::PH_IDLE ||
       next_s.phase == lfm_pkg::PH_SKIP);
    if (pp_mode) begin
      next_s = lfm_pkg::LPC_RESET;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst) begin
      s <= lfm_pkg::LPC_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Parallel port

  lfm_pp_port #(
    .AW        (AW)
  ) u_pp (
    .clk       (CLOCK),
    .rst       (rst),
    .enable    (pp_mode),
    .addr_pins (PP_ADDR),
    .row_sel   (PP_ROW_SEL),
    .oe_n      (PP_OE_N),
    .we_n      (PP_WE_N),
    .dq_in     (PP_DQ_IN),
    .rd_byte   (pp_byte),
    .state     (pp)
  );

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign LAD_OUT       = s.lad.data;
  assign LAD_OE_N      = s.lad.oe_n;
  assign STANDBY       = s.standby;
  assign LPC_MEM_WRITE = s.mem_write;
  assign PP_DQ_OUT     = pp.dq_out;
  assign PP_DQ_OE_N    = pp.dq_oe_n;
  assign PP_WR_STROBE  = pp.wr_strobe;
  assign PP_WR_DATA    = pp.wr_data;
  assign MEM_ADDR      = pp_mode ? pp.addr : s.addr;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (rst);

  mode_quiet_a: assert property (
    pp_mode |=> LAD_OE_N && s.phase == lfm_pkg::PH_IDLE)
    else $error("nibble bus active in parallel mode");

  low_mode_lpc_a: assert property (
    !pp_mode && !LFRAME_N |=> s.phase == lfm_pkg::PH_START)
    else $error("low mode did not start a cycle");

  start_latch_a: assert property (
    !pp_mode && !LFRAME_N |=> s.start == $past(LAD_IN))
    else $error("start nibble not the last one");

  bad_start_a: assert property (
    s.phase == lfm_pkg::PH_START && lpc_live &&
    s.start != lfm_pkg::START_FW_READ &&
    s.start != lfm_pkg::START_FW_WRITE &&
    s.start != lfm_pkg::START_LPC_MEM
    |=> s.phase == lfm_pkg::PH_IDLE && LAD_OE_N)
    else $error("unknown start answered");

  abort_float_a: assert property (
    s.phase inside {[lfm_pkg::PH_ADDR:lfm_pkg::PH_TBACK]} &&
    !pp_mode && !LFRAME_N
    |=> LAD_OE_N && s.phase == lfm_pkg::PH_START)
    else $error("abort not honoured");

  standby_a: assert property (
    !pp_mode && PROG_BUSY |=> !STANDBY)
    else $error("standby while programming");

  direction_a: assert property (
    s.phase == lfm_pkg::PH_START && lpc_live &&
    s.start == lfm_pkg::START_LPC_MEM
    |=> LPC_MEM_WRITE == $past(LAD_IN[lfm_pkg::DIR_BIT]))
    else $error("direction not taken from second nibble");

  id_mismatch_a: assert property (
    s.phase == lfm_pkg::PH_START && lpc_live &&
    s.start == lfm_pkg::START_FW_READ && LAD_IN != ID_STRAP
    |=> LAD_OE_N [*8])
    else $error("bus driven after select mismatch");

  addr_order_a: assert property (
    s.phase == lfm_pkg::PH_ADDR && s.cnt == 3'h0 && lpc_live
    ##1 lpc_live [*6]
    |=> s.phase == lfm_pkg::PH_SIZE &&
        MEM_ADDR[27:24] == $past(LAD_IN, 7))
    else $error("address nibble order wrong");

  size_reject_a: assert property (
    s.phase == lfm_pkg::PH_SIZE && lpc_live &&
    LAD_IN != lfm_pkg::SIZE_ONE_BYTE
    |=> LAD_OE_N [*6])
    else $error("wrong size answered");

  turnaround_a: assert property (
    s.phase == lfm_pkg::PH_TAR0 && lpc_live
    |=> !LAD_OE_N && LAD_OUT == lfm_pkg::TAR_ONES)
    else $error("device did not take the bus");

  read_tail_a: assert property (
    s.phase == lfm_pkg::PH_TAR1 && lpc_live ##1 lpc_live [*3]
    |-> $past(LAD_OUT, 2) == lfm_pkg::SYNC_READY &&
        $past(LAD_OUT, 1) == s.rdata[3:0] &&
        LAD_OUT == s.rdata[7:4])
    else $error("ready code or data order wrong");

  release_a: assert property (
    s.phase == lfm_pkg::PH_DHI && lpc_live
    |=> LAD_OUT == lfm_pkg::TAR_ONES && !LAD_OE_N ##1 LAD_OE_N)
    else $error("return turnaround wrong");

  reset_float_a: assert property (
    @(posedge CLOCK) disable iff (1'b0)
    rst |=> LAD_OE_N && s.phase == lfm_pkg::PH_IDLE)
    else $error("bus driven during reset");

  ident_read_a: assert property (
    s.phase == lfm_pkg::PH_TAR0 && lpc_live && IDENT_MODE &&
    s.addr == lfm_pkg::LPC_IDENT_BASE
    |=> s.rdata == MFR_CODE)
    else $error("maker code not returned");

  full_read_c: cover property (
    s.phase == lfm_pkg::PH_TBACK ##1 s.phase == lfm_pkg::PH_IDLE);
  abort_c: cover property (
    s.phase == lfm_pkg::PH_ADDR && !LFRAME_N);
  mismatch_c: cover property (
    s.phase == lfm_pkg::PH_START && lpc_live &&
    s.start == lfm_pkg::START_FW_READ && LAD_IN != ID_STRAP);
  lpc_mem_c: cover property (
    s.phase == lfm_pkg::PH_START && lpc_live &&
    s.start == lfm_pkg::START_LPC_MEM);

endmodule

//--- tb/lfm_host_model.sv
// Host chipset model: frames nibble-bus cycles, resolves the shared wire
`timescale 1ns/1ns
module lfm_host_model (
  // Clock
  input  wire logic       clk,
  // Device drive
  input  wire logic       lad_oe_n,
  input  wire logic [3:0] lad_out,
  // Host drive and wire
  output logic            lframe_n,
  output logic            init_n,
  output logic [3:0]      lad
);
  logic       host_oe = 1'b1;
  logic [3:0] host_d  = 4'hF;
  logic [3:0] last    = 4'hF;

  initial begin
    lframe_n = 1'b1;
    init_n   = 1'b1;
  end

  // Released wire shows a changing pattern, never the last value
  assign lad = !lad_oe_n ? lad_out : host_oe ? host_d : ~last;
  always @(posedge clk) last <= lad;

  ////////////////////////////////////////////////////////////////////////
  // One read-shaped frame; cut 1 aborts in clock 13, cut 2 resets in 14
  task automatic cycle(input int nlow, input logic [3:0] pre,
      input logic [3:0] st, input logic [3:0] sel, input logic [27:0] a,
      input logic [3:0] sz, input int cut);
    for (int i = 0; i < nlow; i++) begin
      @(posedge clk);
      lframe_n <= 1'b0;
      host_oe  <= 1'b1;
      host_d   <= (i == nlow - 1) ? st : pre;
    end
    for (int c = 2; c <= 17; c++) begin
      @(posedge clk);
      lframe_n <= !(cut == 1 && c == 13);
      init_n   <= !(cut == 2 && c == 14);
      host_oe  <= (c <= 11 || c == 17);
      if (c == 2)
        host_d <= sel;
      else if (c <= 9)
        host_d <= a[27 - 4 * (c - 3) -: 4];
      else if (c == 10)
        host_d <= sz;
      else
        host_d <= 4'hF;
    end
  endtask
endmodule

//--- tb/tb_lfm_target.sv
// Self-checking bench for the flash target read port
`timescale 1ns/1ns
module tb_lfm_target;
  // Arbitrary identification values
  localparam logic [7:0] MFR = 8'h96;
  localparam logic [7:0] DEV = 8'h2B;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] cut;
  } lfm_exp_type;

  logic        clk, rst_n, init_n, mode, ident, busy, standby, mem_wr;
  logic        lframe_n, lad_oe_n, pp_row, pp_oe_n, pp_we_n;
  logic        pp_dq_oe_n, pp_strobe;
  logic [3:0]  lad_in, lad_out, id;
  logic [10:0] pp_addr;
  logic [7:0]  pp_dq, pp_dq_out, pp_wr_data, mem_rd;
  logic [27:0] mem_addr;
  logic [31:0] seed = 32'h011674E3;
  logic [31:0] r;
  logic [19:0] want;
  lfm_exp_type exp_q[$];
  lfm_exp_type me;
  int          n_errors = 0;
  int          compares = 0;

  lfm_target #(.AW(19), .MFR_CODE(MFR), .DEV_CODE(DEV)) dut (
    .CLOCK(clk), .RST_N(rst_n), .INIT_N(init_n), .MODE(mode),
    .IDENT_MODE(ident), .PROG_BUSY(busy), .STANDBY(standby),
    .LPC_MEM_WRITE(mem_wr), .LFRAME_N(lframe_n), .LAD_IN(lad_in),
    .LAD_OUT(lad_out), .LAD_OE_N(lad_oe_n), .ID_STRAP(id),
    .PP_ADDR(pp_addr), .PP_ROW_SEL(pp_row), .PP_OE_N(pp_oe_n),
    .PP_WE_N(pp_we_n), .PP_DQ_IN(pp_dq), .PP_DQ_OUT(pp_dq_out),
    .PP_DQ_OE_N(pp_dq_oe_n), .PP_WR_STROBE(pp_strobe),
    .PP_WR_DATA(pp_wr_data), .MEM_ADDR(mem_addr), .MEM_RD_DATA(mem_rd));

  lfm_host_model host (
    .clk(clk), .lad_oe_n(lad_oe_n), .lad_out(lad_out),
    .lframe_n(lframe_n), .init_n(init_n), .lad(lad_in));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Array contents seen by the port
  function automatic logic [7:0] mem_byte(input logic [27:0] a);
    return a[7:0] ^ a[18:11] ^ 8'h5A;
  endfunction

  always @(posedge clk) mem_rd <= mem_byte(mem_addr);

  task bad(input string msg);
    n_errors++;
    $display("BAD %0t: %s", $time, msg);
  endtask

  task check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
      bad("flag mismatch");
  endtask

  task check_val(input logic [27:0] got, input logic [27:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task done(input string name);
    repeat (2) @(negedge clk);
    check_val(28'(exp_q.size()), 28'h0);
    $display("test %s done", name);
    @(posedge clk);
  endtask

  // Frame through the host; the expected answer comes from the rules
  task automatic rd(input int nlow, input logic [3:0] pre,
      input logic [3:0] st, input logic [3:0] sel, input logic [27:0] a,
      input logic [3:0] sz, input int cut);
    lfm_exp_type e;
    e.data = mem_byte(a);
    if (ident && a == 28'hFBC0000) e.data = MFR;
    if (ident && a == 28'hFBC0001) e.data = DEV;
    e.cut = (cut == 0) ? 3'h5 : (cut == 1) ? 3'h2 : 3'h3;
    if (!mode && st == 4'hD && sel == id && sz == 4'h0)
      exp_q.push_back(e);
    host.cycle(nlow, pre, st, sel, a, sz, cut);
  endtask

  task automatic pp_read(input logic [10:0] row, input logic [7:0] col,
      input logic [7:0] exp);
    @(posedge clk);
    pp_row  <= 1'b1;
    pp_addr <= row;
    @(posedge clk);
    pp_row  <= 1'b0;
    pp_addr <= {3'h0, col};
    @(posedge clk);
    pp_oe_n <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check_val(mem_addr, {9'h000, col, row});
    check_bit(pp_dq_oe_n, 1'b0);
    check_val(28'(pp_dq_out), 28'(exp));
    @(posedge clk);
    pp_oe_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check_bit(pp_dq_oe_n, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watches the wire: every drive must match the oldest note
  initial forever begin
    @(negedge clk);
    if (lad_oe_n === 1'b0) begin
      if (exp_q.size() == 0) begin
        bad("device drove the bus unasked");
      end else begin
        me   = exp_q.pop_front();
        want = {4'hF, 4'h0, me.data[3:0], me.data[7:4], 4'hF};
        for (int k = 0; k < me.cut; k++) begin
          if (k > 0)
            @(negedge clk);
          check_bit(lad_oe_n, 1'b0);
          check_val(28'(lad_out), 28'(want[19 - 4 * k -: 4]));
        end
        @(negedge clk);
        check_bit(lad_oe_n, 1'b1);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad("run did not finish");
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    r       = rnd();
    id      = r[3:0];
    rst_n   = 1'b0;
    mode    = 1'b0;
    ident   = 1'b0;
    busy    = 1'b0;
    pp_addr = 11'h000;
    pp_row  = 1'b1;
    pp_oe_n = 1'b1;
    pp_we_n = 1'b1;
    pp_dq   = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check_bit(standby, 1'b1);
    @(posedge clk);
    busy <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check_bit(standby, 1'b0);
    @(posedge clk);
    busy <= 1'b0;
    done("standby");

    pp_oe_n <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      rd(1, 4'h0, 4'hD, id, r[27:0], 4'h0, 0);
    end
    check_bit(pp_dq_oe_n, 1'b1);
    pp_oe_n <= 1'b1;
    rd(3, 4'h0, 4'hD, id, r[31:4], 4'h0, 0);
    rd(3, 4'hD, 4'h0, id, r[31:4], 4'h0, 0);
    done("reads");

    for (int s = 0; s < 16; s++) begin
      r = rnd();
      rd(1, 4'h0, 4'(s), id, r[27:0], 4'h0, 0);
    end
    done("starts");

    r = rnd();
    rd(1, 4'h0, 4'hD, id ^ (4'h1 | r[3:0]), r[31:4], 4'h0, 0);
    rd(1, 4'h0, 4'hD, id, r[31:4], 4'h1 | r[7:4], 0);
    rd(1, 4'h0, 4'hD, id, r[27:0], 4'h0, 0);
    done("refusals");

    r = rnd();
    rd(1, 4'h0, 4'hD, id, r[27:0], 4'h0, 1);
    rd(1, 4'h0, 4'hD, id, r[31:4], 4'h0, 0);
    rd(1, 4'h0, 4'hD, id, r[27:0], 4'h0, 2);
    rd(1, 4'h0, 4'hD, id, r[31:4], 4'h0, 0);
    done("aborts");

    rd(1, 4'h0, 4'h0, 4'h6, r[27:0], 4'h0, 0);
    check_bit(mem_wr, 1'b1);
    rd(1, 4'h0, 4'h0, 4'h4, r[27:0], 4'h0, 0);
    check_bit(mem_wr, 1'b0);
    done("memory cycles");

    ident <= 1'b1;
    id    <= 4'h0;
    @(posedge clk);
    rd(1, 4'h0, 4'hD, id, 28'hFBC0000, 4'h0, 0);
    rd(1, 4'h0, 4'hD, id, 28'hFBC0001, 4'h0, 0);
    done("ident");

    rst_n <= 1'b0;
    mode  <= 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    pp_read(11'h000, 8'h00, MFR);
    pp_read(11'h001, 8'h00, DEV);
    @(posedge clk);
    ident <= 1'b0;
    r = rnd();
    pp_read(r[10:0], r[18:11], mem_byte({9'h000, r[18:0]}));
    rd(1, 4'h0, 4'hD, id, r[27:0], 4'h0, 0);
    @(posedge clk);
    pp_we_n <= 1'b0;
    @(posedge clk);
    pp_we_n <= 1'b1;
    pp_dq   <= r[31:24];
    @(posedge clk);
    @(negedge clk);
    check_bit(pp_strobe, 1'b1);
    check_val(28'(pp_wr_data), 28'(r[31:24]));
    @(negedge clk);
    check_bit(pp_strobe, 1'b0);
    done("parallel");
    finish_test;
  end
endmodule
